// [mtr_defines.svh]
// constants for the memory type range resolver
`ifndef MTR_DEFINES_SVH
`define MTR_DEFINES_SVH
`define MTR_ADDR_W       36
`define MTR_VAR_COUNT    8
`define MTR_FIX_LIMIT    36'h0_0010_0000
`define MTR_FIX_SEGS     88
`define MTR_TYPE_W       3
`define MTR_TYPE_UC      3'h0
`define MTR_TYPE_WC      3'h1
`define MTR_TYPE_WT      3'h4
`define MTR_TYPE_WP      3'h5
`define MTR_TYPE_WB      3'h6
`define MTR_RESOLVE_LAT  2
`endif

// [mtr_pkg.sv]
// types shared by the memory type range resolver
package mtr_pkg;
   typedef logic [2:0]  mem_type_t;
   typedef logic [35:0] phys_addr_t;
endpackage

// [var_range_match.sv]
// one variable-range entry compare
`include "mtr_defines.svh"
module var_range_match
   import mtr_pkg::*;
(
   input  wire phys_addr_t addr,      // address under test
   input  wire phys_addr_t base,      // entry base
   input  wire phys_addr_t mask,      // entry mask, ones on compared bits
   input  wire logic       valid,     // entry enabled
   output logic            hit        // entry covers addr
);
   // a power-of-two length gives a contiguous mask of high bits
   assign hit = valid && ((addr & mask) == (base & mask));
endmodule

// [memory_type_range_resolver.sv]
// memory type resolver: fixed entries below 1 MB, variable entries above
`include "mtr_defines.svh"
// Overview of operation
// - eight variable-range entries, each with a range and a cache type.
// - fixed entries cover below 1 MB, variable entries the rest.
// - where fixed and variable entries both cover an address, fixed wins.
// - variable overlaps: uncacheable or write-protect beat write-back.
module memory_type_range_resolver
   import mtr_pkg::*;
#(
   parameter int VAR_COUNT = `MTR_VAR_COUNT,  // variable entries
   parameter int FIX_SEGS  = `MTR_FIX_SEGS    // fixed segments below 1 MB
)(
   input  wire logic                    mclk,         // processor clock
   input  wire logic                    rst,          // sync reset, high
   input  wire logic                    lookup_valid, // address presented
   input  wire phys_addr_t              lookup_addr,  // physical address
   input  wire logic                    fix_enable,   // fixed entries on
   input  wire logic                    var_enable,   // variable entries on
   input  wire mem_type_t               default_type, // unused; no-hit type is uncacheable
   input  wire logic [FIX_SEGS*3-1:0]   fix_types,    // per-segment types
   input  wire logic [VAR_COUNT*36-1:0] var_base,     // variable bases
   input  wire logic [VAR_COUNT*36-1:0] var_mask,     // variable masks
   input  wire logic [VAR_COUNT*3-1:0]  var_types,    // variable types
   input  wire logic [VAR_COUNT-1:0]    var_valid,    // variable enables
   output logic                         result_valid, // result strobe
   output mem_type_t                    result_type,  // resolved type
   output logic                         result_fixed, // came from fixed entry
   output logic                         result_miss   // no entry covered
);
   logic [VAR_COUNT-1:0] hit_vec;
   mem_type_t            fix_type;
   logic                 in_fixed;
   logic                 var_any;
   logic                 var_uc, var_wp, var_wb;
   mem_type_t            var_first;
   mem_type_t            type_d;
   logic                 fixed_d, miss_d;
   logic                 stage_v_q;
   phys_addr_t           stage_addr_q;

   // register the address so the compare tree has a full cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         stage_v_q    <= 1'b0;
         stage_addr_q <= '0;
      end else begin
         stage_v_q    <= lookup_valid;
         stage_addr_q <= lookup_addr;
      end
   end

   // every entry compares in parallel, so latency never depends on
   // how many entries firmware has enabled
   genvar gi;
   generate
      for (gi = 0; gi < VAR_COUNT; gi++) begin : g_var
         var_range_match u_match (
            .addr  (stage_addr_q),
            .base  (var_base[gi*36 +: 36]),
            .mask  (var_mask[gi*36 +: 36]),
            .valid (var_valid[gi] & var_enable),
            .hit   (hit_vec[gi])
         );
      end
   endgenerate

   // fixed segment index: 64K units below 512K, 16K units to 768K,
   // 4K units to 1M, like the classic fixed layout
   function automatic int fix_index(input phys_addr_t a);
      if (a[19] == 1'b0)
         return int'(a[18:16]);
      else if (a[18] == 1'b0)
         return 8 + int'(a[17:14]);
      else
         return 24 + int'(a[17:12]);
   endfunction

   assign in_fixed = fix_enable && (stage_addr_q < `MTR_FIX_LIMIT);
   assign fix_type = in_fixed ?
                     mem_type_t'(fix_types[fix_index(stage_addr_q)*3 +: 3])
                     : `MTR_TYPE_UC;

   always_comb begin
      var_any   = 1'b0;
      var_uc    = 1'b0;
      var_wp    = 1'b0;
      var_wb    = 1'b0;
      var_first = `MTR_TYPE_UC;
      for (int i = VAR_COUNT - 1; i >= 0; i--) begin
         if (hit_vec[i]) begin
            var_any   = 1'b1;
            var_first = mem_type_t'(var_types[i*3 +: 3]);
            if (var_types[i*3 +: 3] == `MTR_TYPE_UC)
               var_uc = 1'b1;
            if (var_types[i*3 +: 3] == `MTR_TYPE_WP)
               var_wp = 1'b1;
            if (var_types[i*3 +: 3] == `MTR_TYPE_WB)
               var_wb = 1'b1;
         end
      end
   end

   // other overlap mixes take wb if a wb entry hits, else the lowest entry; firmware must avoid them
   always_comb begin
      fixed_d = 1'b0;
      miss_d  = 1'b0;
      if (in_fixed) begin
         type_d  = fix_type;
         fixed_d = 1'b1;
      end else if (var_uc) begin
         type_d = `MTR_TYPE_UC;
      end else if (var_wp) begin
         type_d = `MTR_TYPE_WP;
      end else if (var_any) begin
         type_d = var_wb ? `MTR_TYPE_WB : var_first;
      end else begin
         type_d = `MTR_TYPE_UC;
         miss_d = 1'b1;
      end
   end

   // default_type is accepted but the no-hit result is held uncacheable
   logic unused_default;
   assign unused_default = ^default_type;

   always_ff @(posedge mclk) begin
      if (rst) begin
         result_valid <= 1'b0;
         result_type  <= `MTR_TYPE_UC;
         result_fixed <= 1'b0;
         result_miss  <= 1'b0;
      end else begin
         result_valid <= stage_v_q;
         result_type  <= type_d;
         result_fixed <= fixed_d;
         result_miss  <= miss_d;
      end
   end

   sequence s_lookup;
      lookup_valid;
   endsequence
   sequence s_answer;
      ##2 result_valid;
   endsequence

   a_answer_latency: assert property (@(posedge mclk) disable iff (rst)
      s_lookup |-> s_answer) else $error("result not after two cycles");
   a_fixed_wins: assert property (@(posedge mclk) disable iff (rst)
      (lookup_valid && fix_enable && lookup_addr < `MTR_FIX_LIMIT)
      |-> ##2 result_fixed) else $error("fixed entry did not win");
   a_high_not_fixed: assert property (
      @(posedge mclk) disable iff (rst)
      (lookup_valid && lookup_addr >= `MTR_FIX_LIMIT)
      |-> ##2 !result_fixed) else $error("fixed entry above 1 MB");
   a_uc_beats_wb: assert property (@(posedge mclk) disable iff (rst)
      (stage_v_q && !in_fixed && var_uc)
      |=> result_type == `MTR_TYPE_UC) else $error("uncacheable lost");
   a_wp_beats_wb: assert property (@(posedge mclk) disable iff (rst)
      (stage_v_q && !in_fixed && !var_uc && var_wp && var_wb)
      |=> result_type == `MTR_TYPE_WP) else $error("write-protect lost");
   a_miss_uc: assert property (@(posedge mclk) disable iff (rst)
      result_miss |-> result_type == `MTR_TYPE_UC)
      else $error("miss not uncacheable");
   a_miss_cause: assert property (@(posedge mclk) disable iff (rst)
      (stage_v_q && !in_fixed && hit_vec == '0) |=> result_miss)
      else $error("uncovered address not flagged");
   a_match_mask: assert property (@(posedge mclk) disable iff (rst)
      (var_enable && var_valid[0] && ((stage_addr_q & var_mask[35:0])
       == (var_base[35:0] & var_mask[35:0]))) |-> hit_vec[0])
      else $error("entry zero failed to match");
   a_disabled_no_hit: assert property (
      @(posedge mclk) disable iff (rst)
      !var_enable |-> hit_vec == '0) else $error("hit while disabled");

   // wb is taken only when no uc or wp entry also covers the address
   a_wb_plain: assert property (@(posedge mclk) disable iff (rst)
      (stage_v_q && !in_fixed && !var_uc && !var_wp && var_wb)
      |=> result_type == `MTR_TYPE_WB) else $error("write-back lost");

   // reset must leave the result side idle, not hold a stale answer
   a_reset_clear: assert property (@(posedge mclk)
      rst |=> (!result_valid && !result_fixed && !result_miss
               && result_type == `MTR_TYPE_UC))
      else $error("result not cleared by reset");
   a_no_stray: assert property (@(posedge mclk) disable iff (rst)
      !stage_v_q |=> !result_valid) else $error("stray result strobe");

   // fixed path in two steps: staged low address, then a fixed answer
   sequence s_stage_low;
      stage_v_q && in_fixed;
   endsequence
   sequence s_fixed_out;
      result_valid && result_fixed && !result_miss;
   endsequence
   a_low_from_fixed: assert property (
      @(posedge mclk) disable iff (rst) s_stage_low |=> s_fixed_out)
      else $error("low address not answered by fixed entry");
   a_fixed_type: assert property (
      @(posedge mclk) disable iff (rst)
      s_stage_low |=> result_type == $past(fix_type))
      else $error("fixed type not passed through");

   // fixed entries switched off must never be reported as the source
   a_fix_off: assert property (@(posedge mclk) disable iff (rst)
      (stage_v_q && !fix_enable) |=> !result_fixed)
      else $error("fixed result while fixed entries off");
   a_fixed_no_miss: assert property (
      @(posedge mclk) disable iff (rst) result_fixed |-> !result_miss)
      else $error("fixed result flagged as miss");
   // any enabled variable hit above the fixed area is not a miss
   a_var_not_miss: assert property (
      @(posedge mclk) disable iff (rst)
      (stage_v_q && !in_fixed && var_any) |=> !result_miss)
      else $error("variable hit flagged as miss");
endmodule

// [memory_type_range_resolver_tb_top.sv]
// self-checking bench for the memory type range resolver
`include "mtr_defines.svh"
module memory_type_range_resolver_tb_top
   import mtr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic         mclk;
   logic         rst;
   logic         lookup_valid;
   logic         fix_enable;
   logic         var_enable;
   phys_addr_t   lookup_addr;
   mem_type_t    default_type;
   mem_type_t    result_type;
   logic [263:0] fix_types;
   logic [287:0] var_base;
   logic [287:0] var_mask;
   logic [23:0]  var_types;
   logic [7:0]   var_valid;
   logic         result_valid;
   logic         result_fixed;
   logic         result_miss;
   int           bad_count;
   int           compares;
   int           cycles = 0;

   memory_type_range_resolver dut_u (
      .mclk(mclk), .rst(rst), .lookup_valid(lookup_valid),
      .lookup_addr(lookup_addr), .fix_enable(fix_enable),
      .var_enable(var_enable), .default_type(default_type),
      .fix_types(fix_types), .var_base(var_base), .var_mask(var_mask),
      .var_types(var_types), .var_valid(var_valid),
      .result_valid(result_valid), .result_type(result_type),
      .result_fixed(result_fixed), .result_miss(result_miss));

   task automatic chk(string name, logic [35:0] seen, logic [35:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic set_var(int i, phys_addr_t b, phys_addr_t m, mem_type_t t);
      var_base[i*36+:36] = b;
      var_mask[i*36+:36] = m;
      var_types[i*3+:3] = t;
      var_valid[i] = 1'b1;
   endtask

   // one lookup; result is due one edge after the taking edge
   task automatic look(phys_addr_t a, mem_type_t t, logic fx, logic ms);
      @(negedge mclk);
      lookup_valid = 1'b1;
      lookup_addr = a;
      @(negedge mclk);
      lookup_valid = 1'b0;
      @(negedge mclk);
      chk("result_valid", result_valid, 1'b1);
      chk("result_type", result_type, t);
      chk("result_fixed", result_fixed, fx);
      chk("result_miss", result_miss, ms);
      // the strobe stands for one cycle only
      @(negedge mclk);
      chk("result_valid_low", result_valid, 1'b0);
   endtask

   task automatic t_fixed();
      fix_types[2:0] = `MTR_TYPE_WT;
      set_var(0, 36'h0_0000_0000, 36'he_0000_0000, `MTR_TYPE_WB);
      look(36'h0_0000_1000, `MTR_TYPE_WT, 1'b1, 1'b0);
      look(36'h0_0010_0000, `MTR_TYPE_WB, 1'b0, 1'b0);
      fix_enable = 1'b0;
      look(36'h0_0000_1000, `MTR_TYPE_WB, 1'b0, 1'b0);
      fix_enable = 1'b1;
   endtask

   task automatic t_overlap();
      set_var(1, 36'h0_f000_0000, 36'hf_f000_0000, `MTR_TYPE_UC);
      look(36'h0_f800_0000, `MTR_TYPE_UC, 1'b0, 1'b0);
      var_types[5:3] = `MTR_TYPE_WP;
      look(36'h0_f800_0000, `MTR_TYPE_WP, 1'b0, 1'b0);
      set_var(2, 36'h1_f800_0000, 36'hf_f800_0000, `MTR_TYPE_UC);
      look(36'h1_fc00_0000, `MTR_TYPE_UC, 1'b0, 1'b0);
      set_var(7, 36'h2_0000_0000, 36'hf_f000_0000, `MTR_TYPE_WB);
      look(36'h2_0800_0000, `MTR_TYPE_WB, 1'b0, 1'b0);
      var_valid[7] = 1'b0;
      look(36'h2_0800_0000, `MTR_TYPE_UC, 1'b0, 1'b1);
   endtask

   task automatic t_miss();
      // low bits match entry 1, only bit 35 differs
      look(36'h8_f800_0000, `MTR_TYPE_UC, 1'b0, 1'b1);
      var_enable = 1'b0;
      look(36'h1_0000_0000, `MTR_TYPE_UC, 1'b0, 1'b1);
      var_enable = 1'b1;
   endtask

   // back-to-back lookups; 16K and 4K fixed segments, then a variable hit
   task automatic t_burst();
      fix_types[29:27] = `MTR_TYPE_WC;
      fix_types[263:261] = `MTR_TYPE_WP;
      @(negedge mclk);
      lookup_valid = 1'b1;
      lookup_addr = 36'h0_0008_4000;
      @(negedge mclk);
      lookup_addr = 36'h0_000f_f000;
      @(negedge mclk);
      lookup_addr = 36'h1_0000_0000;
      chk("burst0_type", result_type, `MTR_TYPE_WC);
      chk("burst0_fixed", result_fixed, 1'b1);
      @(negedge mclk);
      lookup_valid = 1'b0;
      chk("burst1_type", result_type, `MTR_TYPE_WP);
      chk("burst1_valid", result_valid, 1'b1);
      @(negedge mclk);
      chk("burst2_type", result_type, `MTR_TYPE_WB);
      chk("burst2_fixed", result_fixed, 1'b0);
      chk("burst2_valid", result_valid, 1'b1);
   endtask

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count++;
         wrap_up();
      end
   end

   initial begin
      bad_count = 0;
      compares = 0;
      rst = 1'b1;
      lookup_valid = 1'b0;
      lookup_addr = '0;
      fix_enable = 1'b1;
      var_enable = 1'b1;
      // no-hit result must ignore this
      default_type = `MTR_TYPE_WB;
      fix_types = '0;
      var_base = '0;
      var_mask = '0;
      var_types = '0;
      var_valid = '0;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      t_fixed();
      t_overlap();
      t_miss();
      t_burst();
      wrap_up();
   end
endmodule
